// File: bench/ide_host_model.sv
// Far-side model: the queue writer that takes descriptors for the host queue.
// Assumes clk_sys and rst_b of the encoder; mode 0 prompt, 1 random stalls, 2 held off.
`timescale 1ns/10ps
module ide_host_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic desc_valid,
	input wire logic [31:0] desc_word,
	input wire logic [1:0] mode,
	output logic desc_ready
);
	logic [31:0] got[$];

	initial desc_ready = 1'b0;

	// ****************************************
	// Take and pace
	// ****************************************
	always @(posedge clk_sys) begin
		// Words are only logged; a report never hands over a buffer status word
		if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
			got.push_back(desc_word);
		end
		#1;
		desc_ready = rst_b && (mode == 2'h0 || (mode == 2'h1 && $urandom % 3 == 0));
	end
endmodule

// File: bench/test_interrupt_descriptor_encoder.sv
// Self-checking bench for the interrupt descriptor encoder.
// Assumes the host model file is compiled before it.
`timescale 1ns/10ps
module test_interrupt_descriptor_encoder;
	logic clk_sys, rst_b, req_valid, req_dir, req_svc_done, req_buf_done;
	logic buffer_end_irq_enable, req_msg_done, req_pad_last, req_pad_count_nz;
	logic req_pad_end_enable, req_ss7_mode, req_dup_msg, req_err_valid;
	logic desc_ready, desc_valid, write_inhibit;
	logic [2:0] req_group;
	logic [4:0] req_channel;
	logic [7:0] req_pad_prev, req_pad_now, mon_prev, mon_now, out_of_frame_state;
	logic [3:0] req_err_code;
	logic [13:0] buffer_byte_count;
	logic [31:0] desc_word, last_w;
	logic [1:0] mode;
	logic [31:0] exp_q[$];
	int error_cnt, checks, cyc, dups, inh_cnt, rep, ev, k;

	ide_encoder dut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
		.req_dir(req_dir), .req_group(req_group), .req_channel(req_channel),
		.req_svc_done(req_svc_done), .req_buf_done(req_buf_done),
		.buffer_end_irq_enable(buffer_end_irq_enable), .req_msg_done(req_msg_done),
		.req_pad_last(req_pad_last), .req_pad_count_nz(req_pad_count_nz),
		.req_pad_end_enable(req_pad_end_enable), .req_pad_prev(req_pad_prev),
		.req_pad_now(req_pad_now), .req_ss7_mode(req_ss7_mode),
		.signal_unit_error_monitor_prev(mon_prev), .signal_unit_error_monitor_now(mon_now),
		.req_dup_msg(req_dup_msg), .req_err_valid(req_err_valid),
		.req_err_code(req_err_code), .buffer_byte_count(buffer_byte_count),
		.out_of_frame_state(out_of_frame_state), .desc_ready(desc_ready),
		.desc_word(desc_word), .desc_valid(desc_valid), .write_inhibit(write_inhibit));

	ide_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .desc_valid(desc_valid),
		.desc_word(desc_word), .mode(mode), .desc_ready(desc_ready));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Reference model and checks
	// ****************************************
	function automatic logic [31:0] mk(input logic d, input logic [2:0] g,
		input logic [4:0] c, input int e, input logic [3:0] r, input logic [13:0] n);
		return {d, g[1:0], c, e[3:0], r, 1'b0, g[2], n};
	endfunction

	task automatic cmp(input logic [31:0] want, input logic [31:0] seen);
		checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("mismatch t=%0t exp=%h got=%h", $time, want, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		req_valid = 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Wait for the host to catch up, then allow time for any stray extra word
	task automatic drain(input string name);
		int i;
		i = 0;
		while (host.got.size() < exp_q.size() && i < 300) begin
			idle(1);
			i++;
		end
		idle(12);
		cmp(32'(exp_q.size()), 32'(host.got.size()));
		while (exp_q.size() > 0 && host.got.size() > 0) begin
			cmp(exp_q.pop_front(), host.got.pop_front());
		end
		exp_q.delete();
		host.got.delete();
		$display("test %s done", name);
	endtask

	// Codes 20 and up are near misses that must yield no descriptor
	task automatic send(input int e, input bit ok, input logic [3:0] err);
		logic d;
		logic [2:0] g;
		logic [4:0] c;
		logic [13:0] n;
		logic [7:0] m;
		d = (e == 4 || e == 21 || e == 22) ? 1'b1 : (e == 5 || e == 6) ? 1'b0 : 1'($urandom);
		g = 3'($urandom);
		c = 5'($urandom);
		n = (e == 2) ? 14'($urandom) : 14'h0000;
		m = 8'($urandom_range(254, 1));
		req_dir = d;
		req_group = g;
		req_channel = c;
		req_svc_done = (e == 1);
		req_buf_done = (e == 2 || e == 20);
		buffer_end_irq_enable = (e == 2);
		req_msg_done = (e == 3);
		req_pad_last = (e == 4 || e == 21 || e == 22);
		req_pad_count_nz = (e == 4 || e == 21);
		req_pad_end_enable = (e == 4 || e == 22);
		req_pad_prev = (e == 6) ? 8'hFF : 8'h7E;
		req_pad_now = (e == 5) ? 8'hFF : (e == 25) ? 8'h00 : 8'h7E;
		req_ss7_mode = (e >= 8 && e <= 10) ? 1'b1 : (e == 23) ? 1'b0 : 1'($urandom);
		mon_prev = m;
		mon_now = (e == 8 || e == 23) ? m + 8'h01 : (e == 9) ? m - 8'h01 : m;
		req_dup_msg = (e == 10);
		req_err_valid = (err != 4'h0);
		req_err_code = err;
		buffer_byte_count = n;
		req_valid = 1'b1;
		if (e == 10) dups++;
		last_w = mk(d, g, c, e, err, n);
		if (ok) exp_q.push_back(last_w);
		@(posedge clk_sys);
		#1;
	endtask

	always @(posedge clk_sys) begin
		if (write_inhibit === 1'b1) inh_cnt++;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{req_valid, req_dir, req_svc_done, req_buf_done, buffer_end_irq_enable} = 5'h00;
		{req_msg_done, req_pad_last, req_pad_count_nz, req_pad_end_enable} = 4'h0;
		{req_ss7_mode, req_dup_msg, req_err_valid} = 3'h0;
		req_group = 3'h0;
		req_channel = 5'h00;
		req_pad_prev = 8'h7E;
		req_pad_now = 8'h7E;
		mon_prev = 8'h00;
		mon_now = 8'h00;
		req_err_code = 4'h0;
		buffer_byte_count = 14'h0000;
		out_of_frame_state = 8'h00;
		mode = 2'h0;
		rst_b = 1'b0;
		void'($urandom(15));
		repeat (8) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		// Every event code but 7, spaced, under stalls, then back-to-back in runs of up to three
		for (rep = 0; rep < 4; rep++) begin
			mode = (rep == 1) ? 2'h1 : 2'h0;
			for (ev = 0; ev <= 10; ev++) begin
				if (ev != 7) begin
					send(ev, 1'b1, (ev < 4 && ev != 1) ? 4'($urandom_range(15, 1)) : 4'h0);
					if (rep < 2) idle(rep == 1 ? 10 : 3);
					else if (ev % 2 == 1) idle(8);
				end
			end
			drain("events");
		end
		cmp(32'(dups), 32'(inh_cnt));
		// Near misses give no report at all
		for (k = 20; k <= 25; k++) begin
			send(k, 1'b0, 4'h0);
			idle(3);
		end
		drain("no_event");
		// Frame recovery, three groups at once then one alone
		out_of_frame_state = 8'h25;
		idle(4);
		out_of_frame_state = 8'h00;
		exp_q.push_back(mk(1'b0, 3'h0, 5'h00, 7, 4'h0, 14'h0000));
		exp_q.push_back(mk(1'b0, 3'h2, 5'h00, 7, 4'h0, 14'h0000));
		exp_q.push_back(mk(1'b0, 3'h5, 5'h00, 7, 4'h0, 14'h0000));
		idle(10);
		out_of_frame_state = 8'h80;
		idle(4);
		out_of_frame_state = 8'h00;
		exp_q.push_back(mk(1'b0, 3'h7, 5'h00, 7, 4'h0, 14'h0000));
		drain("frame_recovery");
		// Overflow: the sixth word is dropped and flags the newest pending one
		mode = 2'h2;
		idle(2);
		for (k = 0; k < 6; k++) begin
			send(1, k < 4, 4'h0);
			if (k == 4) exp_q.push_back(last_w | 32'h0000_8000);
			idle(4);
		end
		mode = 2'h0;
		drain("lost_flag");
		tally_and_finish();
	end
endmodule

// File: design/ide_desc_ram.sv
// Small descriptor store for the pending queue; read data come out of a register.
// Assumes one write and one read address per cycle on clk_sys.
`timescale 1ns/10ps
module ide_desc_ram (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [ide_pkg::QADDR_W-1:0] wr_addr,
	input wire logic [ide_pkg::DESC_W-1:0] wr_data,
	input wire logic [ide_pkg::QADDR_W-1:0] rd_addr,
	output logic [ide_pkg::DESC_W-1:0] rd_data
);
	typedef struct packed {
		logic [ide_pkg::QUEUE_DEPTH-1:0][ide_pkg::DESC_W-1:0] mem;
		logic [ide_pkg::DESC_W-1:0] rdata;
	} ide_ram_t;

	ide_ram_t st;
	ide_ram_t next_st;

	always_comb begin
		next_st = st;
		next_st.rdata = st.mem[rd_addr];
		if (wr_en) begin
			next_st.mem[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rdata;
endmodule

// File: design/ide_encoder.sv
// Top of the interrupt descriptor encoder: decoder, pending queue and output stage.
// Assumes a queue writer downstream that takes desc_word when desc_valid and desc_ready.
`timescale 1ns/10ps
module ide_encoder (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic req_valid,
	input wire logic req_dir,
	input wire logic [2:0] req_group,
	input wire logic [4:0] req_channel,
	input wire logic req_svc_done,
	input wire logic req_buf_done,
	input wire logic buffer_end_irq_enable,
	input wire logic req_msg_done,
	input wire logic req_pad_last,
	input wire logic req_pad_count_nz,
	input wire logic req_pad_end_enable,
	input wire logic [7:0] req_pad_prev,
	input wire logic [7:0] req_pad_now,
	input wire logic req_ss7_mode,
	input wire logic [7:0] signal_unit_error_monitor_prev,
	input wire logic [7:0] signal_unit_error_monitor_now,
	input wire logic req_dup_msg,
	input wire logic req_err_valid,
	input wire logic [3:0] req_err_code,
	input wire logic [13:0] buffer_byte_count,
	input wire logic [7:0] out_of_frame_state,
	input wire logic desc_ready,
	output logic [31:0] desc_word,
	output logic desc_valid,
	output logic write_inhibit
);
	typedef enum logic [0:0] {
		IDE_IDLE,
		IDE_READ
	} ide_state_t;

	typedef struct packed {
		ide_state_t state;
		logic [ide_pkg::QADDR_W-1:0] head;
		logic [ide_pkg::QADDR_W-1:0] tail;
		logic [ide_pkg::QADDR_W:0] count;
		logic [ide_pkg::QUEUE_DEPTH-1:0] lost_interrupt_flag;
		logic [ide_pkg::DESC_W-1:0] out_word;
		logic out_valid;
		logic inhibit;
	} ide_top_t;

	ide_top_t st;
	ide_top_t next_st;
	ide_link_if lk ();
	logic [ide_pkg::DESC_W-1:0] rd_data;
	logic push;
	logic full;
	logic pop;
	logic [ide_pkg::QADDR_W-1:0] last_idx;

	// ****************************************
	// Request hookup
	// ****************************************
	assign lk.req_valid = req_valid;
	assign lk.req_dir = req_dir;
	assign lk.req_group = req_group;
	assign lk.req_channel = req_channel;
	assign lk.svc_done = req_svc_done;
	assign lk.buf_done = req_buf_done;
	assign lk.buffer_end_irq_enable = buffer_end_irq_enable;
	assign lk.msg_done = req_msg_done;
	assign lk.pad_last = req_pad_last;
	assign lk.pad_count_nz = req_pad_count_nz;
	assign lk.pad_end_enable = req_pad_end_enable;
	assign lk.pad_prev = req_pad_prev;
	assign lk.pad_now = req_pad_now;
	assign lk.ss7_mode = req_ss7_mode;
	assign lk.monitor_prev = signal_unit_error_monitor_prev;
	assign lk.monitor_now = signal_unit_error_monitor_now;
	assign lk.dup_msg = req_dup_msg;
	assign lk.err_valid = req_err_valid;
	assign lk.err_code = req_err_code;
	assign lk.buffer_byte_count = buffer_byte_count;
	assign lk.out_of_frame_state = out_of_frame_state;

	ide_event_decode u_decode (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.lk(lk.det)
	);

	// ****************************************
	// Pending queue
	// ****************************************
	// The entry being popped frees its slot in the same cycle, so a full queue still
	// accepts while the output stage reads.
	assign pop = (st.state == IDE_READ);
	assign full = (st.count == (ide_pkg::QADDR_W + 1)'(ide_pkg::QUEUE_DEPTH)) && !pop;
	assign push = lk.rpt_valid && !full;
	assign last_idx = st.tail - 1'b1;

	ide_desc_ram u_ram (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_en(push),
		.wr_addr(st.tail),
		.wr_data(lk.rpt_word),
		.rd_addr(st.head),
		.rd_data(rd_data)
	);

	always_comb begin
		next_st = st;
		next_st.inhibit = lk.rpt_valid && lk.rpt_inhibit;
		if (push) begin
			next_st.tail = st.tail + 1'b1;
			next_st.lost_interrupt_flag[st.tail] = 1'b0;
		end
		// An overflow marks the newest pending entry instead of making a word of its own
		if (lk.rpt_valid && full) begin
			next_st.lost_interrupt_flag[last_idx] = 1'b1;
		end
		if (push && !pop) begin
			next_st.count = st.count + 1'b1;
		end else if (pop && !push) begin
			next_st.count = st.count - 1'b1;
		end
		if (st.out_valid && desc_ready) begin
			next_st.out_valid = 1'b0;
		end
		unique case (st.state)
			IDE_IDLE: begin
				if (st.count != '0 && (!st.out_valid || desc_ready)) begin
					next_st.state = IDE_READ;
				end
			end
			IDE_READ: begin
				next_st.out_word = rd_data;
				next_st.out_word[ide_pkg::LOST_BIT] = st.lost_interrupt_flag[st.head];
				next_st.out_valid = 1'b1;
				next_st.head = st.head + 1'b1;
				next_st.state = IDE_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign desc_word = st.out_word;
	assign desc_valid = st.out_valid;
	assign write_inhibit = st.inhibit;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_word_taken;
		desc_valid && desc_ready;
	endsequence

	sequence s_word_held;
		desc_valid && !desc_ready;
	endsequence

	a_hold_stable: assert property (s_word_held |=> desc_valid && $stable(desc_word))
		else $error("descriptor changed before taken");
	a_queue_bound: assert property (st.count <= 3'h4)
		else $error("pending count beyond depth");
	a_lost_marks: assert property (lk.rpt_valid && full |=>
		st.lost_interrupt_flag[$past(last_idx)] && st.count == 3'h4)
		else $error("overflow not marked on newest entry");
	a_not_alone: assert property (desc_valid && desc_word[15] |->
		desc_word[23:20] != 4'h0 || desc_word[19:16] != 4'h0)
		else $error("lost flag sent without event or error");
	a_drain_next: assert property (s_word_taken
		##0 (st.count != 3'h0 && st.state == IDE_IDLE) |-> ##2 desc_valid)
		else $error("queue not drained after take");
	a_group_split: assert property ($past(lk.req_valid) && lk.rpt_valid |->
		lk.rpt_word[30:29] == $past(lk.req_group[1:0])
		&& lk.rpt_word[14] == $past(lk.req_group[2]))
		else $error("group field misplaced");
	// Empty queue and free output: the word shows four edges after the request edge
	a_channel_field: assert property (req_valid && req_svc_done && st.count == 3'h0
		&& !desc_valid && !lk.rpt_valid |-> ##4 desc_valid
		&& desc_word[28:24] == $past(req_channel, 4)
		&& desc_word[31] == $past(req_dir, 4)
		&& desc_word[30:29] == $past(req_group[1:0], 4)
		&& desc_word[14] == $past(req_group[2], 4))
		else $error("identity fields wrong");
endmodule

// File: design/ide_event_decode.sv
// Turns one channel request, or a pending frame recovery, into a registered descriptor.
// Assumes the requester presents previous and present pad code and monitor count.
`timescale 1ns/10ps
module ide_event_decode (
	input wire logic clk_sys,
	input wire logic rst_b,
	ide_link_if.det lk
);
	typedef struct packed {
		logic rpt_valid;
		logic [ide_pkg::DESC_W-1:0] rpt_word;
		logic rpt_inhibit;
		logic [ide_pkg::GROUPS-1:0] oof_prev;
		logic [ide_pkg::GROUPS-1:0] frame_recovered_event_pend;
	} ide_dec_t;

	ide_dec_t st;
	ide_dec_t next_st;
	logic [3:0] ev;
	logic combinable;
	logic [2:0] frame_recovered_event_grp;
	logic [ide_pkg::GROUPS-1:0] frame_recovered_event_clr;

	// ****************************************
	// Event selection
	// ****************************************
	always_comb begin
		ev = ide_pkg::EV_NONE;
		combinable = 1'b0;
		if (lk.svc_done) begin
			ev = ide_pkg::service_done_event;
		end else if (lk.ss7_mode && lk.dup_msg) begin
			ev = ide_pkg::duplicate_filtered_event;
		end else if (lk.req_dir && lk.pad_last && lk.pad_count_nz && lk.pad_end_enable) begin
			ev = ide_pkg::padfill_done_event;
		end else if (!lk.req_dir && lk.pad_prev == ide_pkg::PAD_IDLE
				&& lk.pad_now == ide_pkg::PAD_ABORT) begin
			ev = ide_pkg::abort_pattern_change_event;
		end else if (!lk.req_dir && lk.pad_prev == ide_pkg::PAD_ABORT
				&& lk.pad_now == ide_pkg::PAD_IDLE) begin
			ev = ide_pkg::idle_pattern_change_event;
		end else if (lk.ss7_mode && lk.monitor_now > lk.monitor_prev) begin
			ev = ide_pkg::error_monitor_up_event;
		end else if (lk.ss7_mode && lk.monitor_now < lk.monitor_prev) begin
			ev = ide_pkg::error_monitor_down_event;
		end else if (lk.msg_done) begin
			ev = ide_pkg::message_done_event;
			combinable = 1'b1;
		end else if (lk.buf_done && lk.buffer_end_irq_enable) begin
			ev = ide_pkg::buffer_done_event;
			combinable = 1'b1;
		end else begin
			combinable = 1'b1;
		end
	end

	// Lowest pending group wins; others wait for a quiet cycle
	always_comb begin
		frame_recovered_event_grp = 3'h0;
		frame_recovered_event_clr = '0;
		for (int g = ide_pkg::GROUPS - 1; g >= 0; g--) begin
			if (st.frame_recovered_event_pend[g]) begin
				frame_recovered_event_grp = 3'(g);
			end
		end
		if (!lk.req_valid && |st.frame_recovered_event_pend) begin
			frame_recovered_event_clr[frame_recovered_event_grp] = 1'b1;
		end
	end

	always_comb begin
		next_st = st;
		next_st.rpt_valid = 1'b0;
		next_st.rpt_inhibit = 1'b0;
		next_st.oof_prev = lk.out_of_frame_state;
		// A recovery seen in the clear cycle still stays pending
		next_st.frame_recovered_event_pend = (st.frame_recovered_event_pend & ~frame_recovered_event_clr) | (st.oof_prev & ~lk.out_of_frame_state);
		if (lk.req_valid) begin
			// Errors only ride on combinable events, so one event and one error at most
			next_st.rpt_valid = (ev != ide_pkg::EV_NONE) || (lk.err_valid && combinable);
			next_st.rpt_word = ide_pkg::pack_desc(lk.req_dir, lk.req_group, lk.req_channel, ev,
				(lk.err_valid && combinable) ? lk.err_code : 4'h0,
				lk.buffer_byte_count);
			next_st.rpt_inhibit = (ev == ide_pkg::duplicate_filtered_event);
		end else if (|st.frame_recovered_event_pend) begin
			next_st.rpt_valid = 1'b1;
			next_st.rpt_word = ide_pkg::pack_desc(1'b0, frame_recovered_event_grp, 5'h00,
				ide_pkg::frame_recovered_event, 4'h0, 14'h0000);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lk.rpt_valid = st.rpt_valid;
	assign lk.rpt_word = st.rpt_word;
	assign lk.rpt_inhibit = st.rpt_inhibit;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_svc_req;
		lk.req_valid && lk.svc_done;
	endsequence

	a_service_code: assert property (s_svc_req |=> lk.rpt_valid
		&& lk.rpt_word[ide_pkg::EVENT_POS +: 4] == ide_pkg::service_done_event)
		else $error("service done not coded as 1");
	a_event_range: assert property (lk.rpt_valid |->
		lk.rpt_word[ide_pkg::EVENT_POS +: 4] <= ide_pkg::duplicate_filtered_event)
		else $error("reserved event code produced");
	a_abort_change: assert property (lk.req_valid && !lk.svc_done && !lk.dup_msg
		&& !lk.req_dir && lk.pad_prev == 8'h7E && lk.pad_now == 8'hFF |=>
		lk.rpt_word[ide_pkg::EVENT_POS +: 4] == ide_pkg::abort_pattern_change_event)
		else $error("abort pattern change missed");
	a_frame_recov: assert property ($fell(lk.out_of_frame_state[0])
		&& st.frame_recovered_event_pend == '0 |-> ##[1:40] lk.rpt_valid
		&& lk.rpt_word[ide_pkg::EVENT_POS +: 4] == ide_pkg::frame_recovered_event)
		else $error("frame recovery not reported");
	a_dup_inhibit: assert property (lk.rpt_inhibit |-> lk.rpt_valid
		&& lk.rpt_word[ide_pkg::EVENT_POS +: 4] == ide_pkg::duplicate_filtered_event)
		else $error("inhibit without filtered event");
	a_error_kept: assert property (lk.req_valid && lk.err_valid && !lk.svc_done
		&& !lk.ss7_mode && !lk.pad_last && lk.pad_prev == lk.pad_now |=>
		lk.rpt_valid && lk.rpt_word[ide_pkg::ERR_POS +: 4] == $past(lk.err_code))
		else $error("error code not reported");
endmodule

// File: include/ide_link_if.sv
// Carries a request from the encoder top to the event decoder and the report back.
// Assumes both ends sit on clk_sys.
`timescale 1ns/10ps
interface ide_link_if;
	logic req_valid;
	logic req_dir;
	logic [2:0] req_group;
	logic [4:0] req_channel;
	logic svc_done;
	logic buf_done;
	logic buffer_end_irq_enable;
	logic msg_done;
	logic pad_last;
	logic pad_count_nz;
	logic pad_end_enable;
	logic [7:0] pad_prev;
	logic [7:0] pad_now;
	logic ss7_mode;
	logic [7:0] monitor_prev;
	logic [7:0] monitor_now;
	logic dup_msg;
	logic err_valid;
	logic [3:0] err_code;
	logic [13:0] buffer_byte_count;
	logic [7:0] out_of_frame_state;
	logic rpt_valid;
	logic [31:0] rpt_word;
	logic rpt_inhibit;
	modport top (output req_valid, req_dir, req_group, req_channel, svc_done, buf_done,
		buffer_end_irq_enable, msg_done, pad_last, pad_count_nz, pad_end_enable, pad_prev,
		pad_now, ss7_mode, monitor_prev, monitor_now, dup_msg, err_valid, err_code,
		buffer_byte_count, out_of_frame_state, input rpt_valid, rpt_word, rpt_inhibit);
	modport det (input req_valid, req_dir, req_group, req_channel, svc_done, buf_done,
		buffer_end_irq_enable, msg_done, pad_last, pad_count_nz, pad_end_enable, pad_prev,
		pad_now, ss7_mode, monitor_prev, monitor_now, dup_msg, err_valid, err_code,
		buffer_byte_count, out_of_frame_state, output rpt_valid, rpt_word, rpt_inhibit);
endinterface

// File: include/ide_pkg.sv
// Constants, field layout and descriptor packing for the interrupt descriptor encoder.
// Assumes one system clock; every request arrives from logic on that clock.
// How it works
// - Each report is one 32-bit word: direction, group, channel, event, error, count.
// - A descriptor holds at most one event code and one error code.
// - Lost-interrupt flag is only set inside a pending descriptor, never sent alone.
// - An error given with a request appears only with no event or code 2 or 3; write order is loose.
// - Bit 31 is the direction: 0 receive, 1 transmit.
// - Group bits 1:0 go to bits 30:29, group bit 2 to bit 14.
// - Channel 0 to 31 goes to bits 28:24.
// - Event field 23:20 is 0 for no event; codes 11 to 15 never appear.
// - Code 2 on buffer done with its end interrupt enabled, with byte count.
// - Code 3 on end of message, as reported by transmit or receive engine.
// - Code 4 on last idle octet of nonzero padfill, only when reporting enabled.
// - Code 5 when received pad code goes from 7Eh to FFh.
// - Code 6 when received pad code goes from FFh to 7Eh.
// - Code 7 when a serial port leaves out-of-frame state.
// - Code 8 when the error rate monitor count rises in SS7 mode.
// - Code 9 when the error rate monitor count falls in SS7 mode.
// - Code 10 on a repeated SS7 message, whose memory write is suppressed.
package ide_pkg;
	// ****************************************
	// Descriptor fields
	// ****************************************
	localparam int DIR_BIT = 31;
	localparam int GRP_LO_POS = 29;
	localparam int GRP_HI_BIT = 14;
	localparam int CH_POS = 24;
	localparam int EVENT_POS = 20;
	localparam int ERR_POS = 16;
	localparam int LOST_BIT = 15;
	localparam int COUNT_POS = 0;
	localparam int DESC_W = 32;
	localparam int COUNT_W = 14;
	localparam int GROUPS = 8;
	localparam int QUEUE_DEPTH = 4;
	localparam int QADDR_W = 2;
	localparam logic [DESC_W-1:0] DESC_RESET = 32'h0000_0000;
	localparam logic [7:0] PAD_IDLE = 8'h7E;
	localparam logic [7:0] PAD_ABORT = 8'hFF;

	// ****************************************
	// Event codes
	// ****************************************
	localparam logic [3:0] EV_NONE = 4'h0;
	localparam logic [3:0] service_done_event = 4'h1;
	localparam logic [3:0] buffer_done_event = 4'h2;
	localparam logic [3:0] message_done_event = 4'h3;
	localparam logic [3:0] padfill_done_event = 4'h4;
	localparam logic [3:0] abort_pattern_change_event = 4'h5;
	localparam logic [3:0] idle_pattern_change_event = 4'h6;
	localparam logic [3:0] frame_recovered_event = 4'h7;
	localparam logic [3:0] error_monitor_up_event = 4'h8;
	localparam logic [3:0] error_monitor_down_event = 4'h9;
	localparam logic [3:0] duplicate_filtered_event = 4'hA;

	function automatic logic [DESC_W-1:0] pack_desc(input logic dir, input logic [2:0] group_number_field,
		input logic [4:0] ch, input logic [3:0] ev, input logic [3:0] err,
		input logic [COUNT_W-1:0] cnt);
		logic [DESC_W-1:0] w;
		w = DESC_RESET;
		w[DIR_BIT] = dir;
		w[GRP_LO_POS +: 2] = group_number_field[1:0];
		w[GRP_HI_BIT] = group_number_field[2];
		w[CH_POS +: 5] = ch;
		w[EVENT_POS +: 4] = ev;
		w[ERR_POS +: 4] = err;
		w[COUNT_POS +: COUNT_W] = cnt;
		return w;
	endfunction
endpackage
